// File: shared/smbcfg_pkg.sv
/*
  constants for the second smbus port configuration block: register address,
  field positions, reset value, rate source codes and timing counts.
  assumes a single 20 MHz system clock domain.
*/
package smbcfg_pkg;
  localparam logic [7:0] CFG_ADDR      = 8'hC1;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam int         BIT_ENABLE    = 7;
  localparam int         BIT_INHIBIT   = 6;
  localparam int         BIT_BUSY      = 5;
  localparam int         BIT_HOLDEXT   = 4;
  localparam int         BIT_LOWTO_EN  = 3;
  localparam int         BIT_FREETO_EN = 2;
  localparam int         SEL_HI        = 1;
  localparam int         SEL_LO        = 0;
  localparam logic [1:0] SRC_T0        = 2'h0;
  localparam logic [1:0] SRC_T5        = 2'h1;
  localparam logic [1:0] SRC_T2_HIGH   = 2'h2;
  localparam logic [1:0] SRC_T2_LOW    = 2'h3;
  localparam int         FREE_PERIODS  = 10;
  localparam int         FREE_CNT_W    = 4;
  localparam int         LOWTO_MS      = 25;
  localparam int         CLK_HZ        = 20000000;
  // advisory figure for the timer the firmware programs
  localparam int         LOWTO_CYCLES  = (CLK_HZ / 1000) * LOWTO_MS;
endpackage : smbcfg_pkg

// File: rtl/smbcfg_sync.sv
/*
  two flip-flop synchroniser for a vector of pin levels.
  assumes inputs are asynchronous to ref_clk; reset level is a parameter.
*/
`timescale 1ns/100ps
module smbcfg_sync #(
  parameter int           W      = 2,
  parameter logic [W-1:0] RSTVAL = '1
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= RSTVAL;
      dout   <= RSTVAL;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : smbcfg_sync

// File: rtl/smbcfg_port1.sv
/*
  configuration and bus supervision for smbus port 1: the config register,
  busy tracking by start/stop, free-bus timeout, clock-low timeout timer
  control, rate source selection and slave interrupt gating.
  assumes a cpu special-function-register strobe interface on ref_clk, and
  bus lines and timer overflows arriving from other clock domains.
*/
`timescale 1ns/100ps
// Functional notes
// - enable bit 7 activates the port; it then watches both bus lines.
// - inhibit bit 6 blocks interrupts from slave events.
// - master events still interrupt while inhibit is set.
// - busy bit 5 is set by hardware while a transfer is running.
// - busy clears on a stop or on the free-bus timeout.
// - bit 4 selects normal (0) or extended (1) data setup/hold timing.
// - bit 3 reloads the timeout timer while clock is high, counts when low.
// - with a split timer only its high byte is held in reload.
// - bit 2: bus free after both lines high over 10 source periods.
// - bits 1:0 pick timer 0, timer 5, timer 2 high or timer 2 low overflow.
module smbcfg_port1 (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // cpu register strobes, same clock
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrite,
  input  wire logic       sfrRead,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  // bus wires, asynchronous to ref_clk
  input  wire logic       port1_clock_line,
  input  wire logic       port1_data_line,
  // timer overflow levels, treated as asynchronous
  input  wire logic       timer0Ovf,
  input  wire logic       timer5Ovf,
  input  wire logic       timer2HighOvf,
  input  wire logic       timer2LowOvf,
  // same-clock status and event levels
  input  wire logic       timerSplitMode,
  input  wire logic       slaveEvent,
  input  wire logic       masterEvent,
  // configuration and supervision results
  output logic            portActive,
  output logic            holdExtended,
  output logic            rateTick,
  output logic            timerReloadHigh,
  output logic            timerReloadLow,
  output logic            portIrq,
  output logic            busFree,
  output logic            startSeen,
  output logic            stopSeen
);
  // cfg keeps the busy position at zero; the live flag is merged on read
  // so a write can never fake or hide a transfer in progress
  logic [7:0] cfg;
  logic       port1_busy_flag;
  logic [1:0] lineSync;
  logic [1:0] linePrev;
  logic [3:0] ovfSync;
  logic [3:0] ovfPrev;
  logic [smbcfg_pkg::FREE_CNT_W-1:0] freeCnt;

  wire port1_enable_bit           = cfg[smbcfg_pkg::BIT_ENABLE];
  wire port1_slave_inhibit        = cfg[smbcfg_pkg::BIT_INHIBIT];
  wire port1_hold_extension       = cfg[smbcfg_pkg::BIT_HOLDEXT];
  wire port1_clock_low_timeout_en = cfg[smbcfg_pkg::BIT_LOWTO_EN];
  wire port1_free_timeout_en      = cfg[smbcfg_pkg::BIT_FREETO_EN];
  wire [1:0] port1_rate_source_sel = cfg[smbcfg_pkg::SEL_HI:smbcfg_pkg::SEL_LO];

  wire cfgHit   = (sfrAddr == smbcfg_pkg::CFG_ADDR);
  wire cfgWrite = sfrWrite && cfgHit;
  wire sclNow   = lineSync[1];
  wire sdaNow   = lineSync[0];
  wire sclPrev  = linePrev[1];
  wire sdaPrev  = linePrev[0];

  // both line levels are synchronised always; the enable gates the
  // detectors instead, so re-enabling never sees stale stage values
  // reset level is high, matching released wires with pull-ups
  smbcfg_sync #(.W(2), .RSTVAL(2'h3)) u_line_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     ({port1_clock_line, port1_data_line}),
    .dout    (lineSync)
  );

  // overflow strobes come from timer logic that may run on another clock,
  // so they are treated as levels and their rising edges are taken here
  smbcfg_sync #(.W(4), .RSTVAL(4'h0)) u_ovf_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     ({timer2LowOvf, timer2HighOvf, timer5Ovf, timer0Ovf}),
    .dout    (ovfSync)
  );

  wire [3:0] ovfRise = ovfSync & ~ovfPrev;

  // the source code is decoded in one place only
  function automatic logic rate_pick(
    input logic [1:0] sel,
    input logic [3:0] rise
  );
    logic pick;
    pick = 1'b0;
    unique case (sel)
      smbcfg_pkg::SRC_T0:      pick = rise[0];
      smbcfg_pkg::SRC_T5:      pick = rise[1];
      smbcfg_pkg::SRC_T2_HIGH: pick = rise[2];
      smbcfg_pkg::SRC_T2_LOW:  pick = rise[3];
    endcase
    return pick;
  endfunction : rate_pick

  // start: data falls while clock high; stop: data rises while clock high
  // clock must be high on two samples, so a data change that lands with
  // the clock edge in one sample is not taken for a start or a stop
  wire startDet = port1_enable_bit && sclNow && sclPrev && sdaPrev && !sdaNow;
  wire stopDet  = port1_enable_bit && sclNow && sclPrev && !sdaPrev && sdaNow;

  // a tick from the selected source marks one bit-rate period
  assign rateTick = rate_pick(port1_rate_source_sel, ovfRise);

  // the free counter only advances while both lines sit high
  wire linesHigh   = sclNow && sdaNow;
  wire freeArmed   = port1_enable_bit && port1_free_timeout_en && linesHigh;
  wire freeAtLimit = (freeCnt == smbcfg_pkg::FREE_CNT_W'(smbcfg_pkg::FREE_PERIODS));
  // the first period after the lines rise may be partial, hence the
  // timeout waits for one tick beyond the documented count
  wire freeTimeout = freeArmed && rateTick && freeAtLimit;

  // busy tracks transfers seen on the wires, whoever drives them; it is
  // only as good as the detectors, so a frame that starts while the port
  // is off is not seen until the next start or the free timeout
  // busy set wins over a same-cycle stop so a fresh start is never lost
  wire next_busy = !port1_enable_bit ? 1'b0 :
                   startDet          ? 1'b1 :
                   (stopDet || freeTimeout) ? 1'b0 :
                   port1_busy_flag;

  // reload follows the synchronised clock level, so the timer starts
  // counting about two cycles after the wire falls; negligible against
  // a timeout of many milliseconds
  wire reloadReq = port1_enable_bit && port1_clock_low_timeout_en && sclNow;
  assign timerReloadHigh = reloadReq;
  assign timerReloadLow  = reloadReq && !timerSplitMode;

  // the inhibit masks slave events only; master events pass whenever the port is enabled
  assign portIrq = port1_enable_bit && (masterEvent || (slaveEvent && !port1_slave_inhibit));

  assign portActive   = port1_enable_bit;
  assign holdExtended = port1_hold_extension;
  assign busFree      = !port1_busy_flag;
  assign startSeen    = startDet;
  assign stopSeen     = stopDet;

  // read view: stored fields with the live busy flag in its place
  wire [7:0] readValue = {cfg[7:6], port1_busy_flag, cfg[4:0]};

  // config register: only a write strobe to its own address changes it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= smbcfg_pkg::CFG_RESET;
    end else if (cfgWrite) begin
      // the busy position is hardware owned and never stored from a write
      cfg <= sfrWdata & ~(8'h01 << smbcfg_pkg::BIT_BUSY);
    end
  end

  // busy flag, hardware owned
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port1_busy_flag <= 1'b0;
    end else begin
      port1_busy_flag <= next_busy;
    end
  end

  // previous samples for edge detection; reset matches the idle levels
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      linePrev <= 2'h3;
      ovfPrev  <= 4'h0;
    end else begin
      linePrev <= lineSync;
      ovfPrev  <= ovfSync;
    end
  end

  // read data stands one cycle and is zero otherwise, so an
  // unmapped read cannot pick up a stale value
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sfrRdata <= 8'h00;
    end else begin
      sfrRdata <= (sfrRead && cfgHit) ? readValue : 8'h00;
    end
  end

  // counts source periods with both lines high; restarts on any low level
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      freeCnt <= '0;
    end else if (!freeArmed || freeTimeout) begin
      freeCnt <= '0;
    end else if (rateTick && !freeAtLimit) begin
      freeCnt <= freeCnt + smbcfg_pkg::FREE_CNT_W'(1);
    end
  end
endmodule : smbcfg_port1

// File: test/smbcfg_bus_model.sv
/* another party on the port-1 wires: start, one byte, then an end.
   assumes pull-ups hold both wires high once released. */
`timescale 1ns/100ps
module smbcfg_bus_model (
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hdr(input logic [7:0] b);
    sda = 1'b0;
    #200 scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sda = b[i];
      #200 scl = 1'b1;
      #200 scl = 1'b0;
    end
  endtask : hdr
  // no stop leaves the free timeout as the only way out of busy
  task automatic fin(input logic withStop);
    sda = !withStop;
    #200 scl = 1'b1;
    #200 sda = 1'b1;
  endtask : fin
endmodule : smbcfg_bus_model

// File: test/smbcfg_port1_properties.sv
/* timing relations on the smbcfg_port1 ports.
   assumes a bind onto the block; one clock domain. */
`timescale 1ns/100ps
module smbcfg_port1_properties (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrite,
  input wire logic       sfrRead,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  input wire logic       port1_clock_line,
  input wire logic       timerSplitMode,
  input wire logic       masterEvent,
  input wire logic       portActive,
  input wire logic       holdExtended,
  input wire logic       timerReloadHigh,
  input wire logic       timerReloadLow,
  input wire logic       portIrq,
  input wire logic       busFree,
  input wire logic       startSeen,
  input wire logic       stopSeen
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence cfgWrite;
    sfrWrite && sfrAddr == 8'hC1;
  endsequence
  sequence cfgRead;
    sfrRead && sfrAddr == 8'hC1;
  endsequence
  a_enable_write: assert property (cfgWrite |=> portActive == $past(sfrWdata[7]))
    else $error("enable bit wrong");
  a_holdext_write: assert property (cfgWrite |=> holdExtended == $past(sfrWdata[4]))
    else $error("hold extension wrong");
  a_master_irq: assert property (portActive && masterEvent |-> portIrq)
    else $error("master event lost");
  a_start_busy: assert property (startSeen && portActive |-> ##[1:2] !busFree)
    else $error("start left bus free");
  a_stop_free: assert property (stopSeen && !startSeen |-> ##[1:2] busFree)
    else $error("stop left bus busy");
  a_split_reload: assert property (timerReloadLow == (timerReloadHigh && !timerSplitMode))
    else $error("low byte reload wrong");
  a_scl_low_count: assert property (!port1_clock_line [*4] |-> !timerReloadHigh)
    else $error("reload while clock low");
  a_cfg_readback: assert property (cfgRead |=> sfrRdata[7] == $past(portActive))
    else $error("readback wrong");
  a_unmapped_read: assert property (sfrRead && sfrAddr != 8'hC1 |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : smbcfg_port1_properties

// File: test/tb.sv
/* bench for smbcfg_port1: random config, frames, free timeout per source.
   assumes the bus model and the checker are compiled first. */
`timescale 1ns/100ps
module tb;
  logic       ref_clk = 1'b0, resetn = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, w;
  logic [3:0] ovf = 4'h0;
  logic       timerSplitMode = 1'b0, slaveEvent = 1'b0, masterEvent = 1'b0;
  logic       port1_clock_line, port1_data_line, portActive, holdExtended, rateTick;
  logic       timerReloadHigh, timerReloadLow, portIrq, busFree, startSeen, stopSeen;
  int         nFail = 0, testsRun = 0, cycles = 0, seed = 32'hD2DF7820, r;
  wire  [4:0] outs = {portActive, holdExtended, portIrq, timerReloadHigh, timerReloadLow};
  smbcfg_bus_model i_bus (.scl(port1_clock_line), .sda(port1_data_line));
  smbcfg_port1 i_dut (.*, .timer0Ovf(ovf[0]), .timer5Ovf(ovf[1]),
    .timer2HighOvf(ovf[2]), .timer2LowOvf(ovf[3]));
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cycles == 20000) begin
    nFail++;
    summarize();
  end
  function automatic logic [7:0] expOuts(input logic [7:0] c);
    return 8'({c[7], c[4], c[7] & (masterEvent | slaveEvent & !c[6]), c[7] & c[3],
      c[7] & c[3] & !timerSplitMode});
  endfunction : expOuts
  task automatic chk(input string nm, input logic [7:0] got, exp);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [7:0] a, d);
    @(posedge ref_clk);
    {sfrWrite, sfrRead, sfrAddr, sfrWdata} <= {wr, !wr, a, d};
    @(posedge ref_clk);
    {sfrWrite, sfrRead} <= 2'b00;
    @(negedge ref_clk);
  endtask : acc
  // pulses two cycles wide so the synchroniser cannot miss one
  task automatic tick(input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge ref_clk) ovf <= m;
      repeat (2) @(posedge ref_clk);
      ovf <= 4'h0;
      repeat (3) @(posedge ref_clk);
    end
    repeat (6) @(negedge ref_clk);
  endtask : tick
  task automatic summarize();
    $display("checks %0d failures %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    acc(1'b1, 8'hC0, 8'hFF);
    acc(1'b0, 8'hC1, 8'h00);
    chk("reset", sfrRdata, 8'h00);
    // firmware sizes its clock-low timer for 25 ms of system clocks
    chk("lowto", 8'(smbcfg_pkg::LOWTO_CYCLES / 2000), 8'hFA);
    for (int s = 0; s < 4; s++) begin
      r = $random(seed);
      w = {1'b1, s == 1 || s == 2 || r[6], r[5:3], 1'b1, 2'(s)};
      @(posedge ref_clk);
      {timerSplitMode, slaveEvent, masterEvent} <= {r[7], s == 1 ? 2'b01 : s == 2 ? 2'b10 : r[9:8]};
      acc(1'b1, 8'hC1, w);
      acc(1'b0, 8'hC1, 8'h00);
      chk("config", sfrRdata, w & 8'hDF);
      chk("outputs", 8'(outs), expOuts(w));
      i_bus.hdr(r[31:24]);
      acc(1'b0, 8'hC1, 8'h00);
      chk("busy", sfrRdata, w & 8'hDF | 8'h20);
      i_bus.fin(1'b0);
      tick(~(4'h1 << s), 12);
      chk("held", 8'(busFree), 8'h00);
      tick(4'h1 << s, 10);
      chk("ten", 8'(busFree), 8'h00);
      tick(4'h1 << s, 1);
      chk("free", 8'(busFree), 8'h01);
      i_bus.hdr(r[23:16]);
      chk("busy2", 8'(busFree), 8'h00);
      i_bus.fin(1'b1);
      repeat (6) @(negedge ref_clk);
      chk("stop", 8'(busFree), 8'h01);
    end
    summarize();
  end
endmodule : tb
bind smbcfg_port1 smbcfg_port1_properties i_props (.*);
